// [prs_pkg.sv]
/*
 * Constants for the PLL reference select and divider control block:
 * register offsets, field positions, reset values, mode codes, widths.
 * Assumes an 8-bit register port with byte offsets as listed here.
 */
package prs_pkg;

	// Register port
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam logic [8:0] REG_PLL_CTRL = 9'h010;
	localparam logic [8:0] REG_RDIV_LO = 9'h011;
	localparam logic [8:0] REG_RDIV_HI = 9'h012;
	localparam logic [8:0] REG_ADIV = 9'h013;
	localparam logic [8:0] REG_BDIV_LO = 9'h014;
	localparam logic [8:0] REG_BDIV_HI = 9'h015;
	localparam logic [8:0] REG_PSC = 9'h016;
	localparam logic [8:0] REG_LD_CTRL = 9'h018;
	localparam logic [8:0] REG_SYNC_CTRL = 9'h019;
	localparam logic [8:0] REG_MON_CFG = 9'h01B;
	localparam logic [8:0] REG_REF_CTRL = 9'h01C;
	localparam logic [8:0] REG_REF_PREF = 9'h01D;
	localparam logic [8:0] REG_STATUS = 9'h01F;

	// Reset values
	localparam logic [7:0] PLL_CTRL_RST = 8'h01;
	localparam logic [7:0] ZERO_RST = 8'h00;
	localparam logic [1:0] PLL_PD_NORMAL = 2'h0;

	// Reference control fields
	localparam int REF_DIFF_BIT = 0;
	localparam int REF_PRI_EN_BIT = 1;
	localparam int REF_SEC_EN_BIT = 2;
	localparam int REF_XTAL_BIT = 3;
	localparam int REF_MAN_SEC_BIT = 4;
	localparam int REF_AUTO_BIT = 5;
	localparam int REF_PIN_SEL_BIT = 6;
	localparam int REF_DEGLITCH_DIS_BIT = 7;
	localparam int PREF_SEC_BIT = 0;
	localparam int PREF_STATUS_BIT = 1;
	localparam int LD_SE_OFFSET_BIT = 7;
	localparam int PSC_AB_RST_BIT = 4;
	localparam int PSC_SHARED_RST_BIT = 5;
	localparam int PSC_R_RST_BIT = 6;
	localparam int SYNC_LSB = 6;

	// Monitor and status pin source codes
	localparam logic [3:0] MON_PRI_LOST = 4'h7;
	localparam logic [3:0] MON_SEC_LOST = 4'h8;
	localparam logic [3:0] STAT_PRI_LOST = 4'hF;
	localparam logic [3:0] STAT_SEC_LOST = 4'hE;

	// Sync pin reset modes
	typedef enum logic [1:0] {
		PRS_SYNC_OFF = 2'b00,
		PRS_SYNC_LEVEL = 2'b01,
		PRS_SYNC_EDGE = 2'b10,
		PRS_SYNC_RSVD = 2'b11
	} prs_sync_t;

	// Prescaler modes
	typedef enum logic [2:0] {
		PRS_FD1 = 3'b000,
		PRS_FD2 = 3'b001,
		PRS_DM2 = 3'b010,
		PRS_DM4 = 3'b011,
		PRS_DM8 = 3'b100,
		PRS_DM16 = 3'b101,
		PRS_DM32 = 3'b110,
		PRS_FD3 = 3'b111
	} prs_psc_t;

	// Divider widths
	localparam int R_W = 14;
	localparam int A_W = 6;
	localparam int B_W = 13;
	localparam int P_W = 6;
	localparam logic [R_W-1:0] R_ONE = 14'h0001;
	localparam logic [B_W-1:0] B_ONE = 13'h0001;
	localparam logic [A_W-1:0] A_ONE = 6'h01;
	localparam logic [P_W-1:0] P_ONE = 6'h01;

	// Reference loss timeout
	localparam int CLK_PERIOD_NS = 40;
	localparam int REF_LOSS_NS = 2000;
	localparam int REF_LOSS_CYC = REF_LOSS_NS / CLK_PERIOD_NS;

endpackage

// [prs_ref_ctrl.sv]
/*
 * Reference input select, switchover and R/N divider control.
 * Assumes reference, feedback and pin inputs are asynchronous to
 * core_clk_in and much slower than it; registers are written over a
 * plain strobed port in the core clock domain.
 */
// The register offsets and the address-and-strobe port were chosen for this implementation.
// Function
// - All reference input paths are off after reset until software enables one.
// - Differential receiver is powered down unless selected and PLL is on.
// - Single-ended buffers power down on PLL off, own disable, or differential mode.
// - Offset bit set engages DC bias shift on single-ended inputs.
// - Crystal amplifier is enabled only while its enable bit is set.
// - Switching primary and secondary only exists in dual single-ended mode.
// - Manual selection comes from the register bit or the select pin.
// - Monitor output high while primary invalid, switching to secondary, then back.
// - Status output may drive switching; secondary may be the preferred reference.
// - While deglitching, no edge passes until the new reference edge arrives.
// - Automatic selection always reverts to the preferred reference once valid.
// - Reference divider is 14 bits, written through two byte registers.
// - Reference divider values zero and one both divide by one.
// - Reference divider resets by own bit, shared bit, or sync.
// - Feedback ratio equals prescaler modulus times main count plus swallow count.
// - Three-bit prescaler field picks fixed 1, 2, 3 or dual-modulus P/P+1.
// - Fixed-divide modes ignore the swallow count, treating it as zero.
// - Fixed and dual-modulus modes together cover every ratio up to maximum.
// - Main count of one bypasses it; divide equals prescaler setting alone.
// - Feedback counters reset by own or shared bit; bits never self-clear.
// - Two-bit field enables sync pin reset of all counters; off after reset.
`timescale 1ns/1ps

module prs_ref_ctrl import prs_pkg::*; #(
	parameter int LOSS_CYC = REF_LOSS_CYC
) (
	// Clock, reset, enable
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Register port
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [DATA_W-1:0] rd_data_out,
	// Pins from outside the clock domain
	input wire logic primary_reference_input_in,
	input wire logic secondary_reference_input_in,
	input wire logic vco_feedback_in,
	input wire logic sync_n_in,
	input wire logic ref_select_pin_in,
	// Analog front end controls
	output logic diff_rx_pd_out,
	output logic primary_buf_pd_out,
	output logic secondary_buf_pd_out,
	output logic se_offset_out,
	output logic crystal_oscillator_enable_out,
	// Selection and monitor pins
	output logic ref_sel_secondary_out,
	output logic reference_monitor_output_out,
	output logic status_out,
	// Divided clocks towards the phase detector
	output logic r_div_pulse_out,
	output logic n_div_pulse_out
);

	localparam int NPIN = 5;
	// Idle pin levels; the sync pin rests high, so no false sync after reset
	localparam logic [NPIN-1:0] PIN_IDLE = 5'h08;
	localparam int LW = $clog2(LOSS_CYC + 1);
	localparam logic [LW-1:0] LOSS_LIM = LW'(LOSS_CYC);

	logic [7:0] pll_ctrl, r_lo, r_hi, a_reg, b_lo, b_hi, psc_reg;
	logic [7:0] ld_ctrl, sync_ctrl, mon_cfg, ref_ctrl, ref_pref;
	logic [NPIN-1:0] pin_raw, s1, s2, s3, filt, rise, fall;
	logic [1:0] ref_valid;
	logic [LW-1:0] loss_cnt [2];
	logic pll_pd, diff_sel, pri_en, sec_en, dual, deg_dis, fixed_sec;
	logic drive, target_sec, sel_sec, pending, new_edge, ref_edge, path_on;
	logic sync_rst, r_rst, n_rst;
	logic [R_W-1:0] r_val, r_cnt, r_load, r_eff;
	logic [A_W-1:0] a_val, a_eff, a_cnt;
	logic [B_W-1:0] b_val, b_eff, b_cnt;
	logic [P_W-1:0] psc_cnt, p_mod;
	prs_psc_t psc_mode, psc_q;
	prs_sync_t sync_mode;

	// Prescaler base modulus per mode
	function automatic logic [P_W-1:0] p_base(input prs_psc_t m);
		case (m)
			PRS_FD1: p_base = 6'h01;
			PRS_FD2, PRS_DM2: p_base = 6'h02;
			PRS_FD3: p_base = 6'h03;
			PRS_DM4: p_base = 6'h04;
			PRS_DM8: p_base = 6'h08;
			PRS_DM16: p_base = 6'h10;
			default: p_base = 6'h20;
		endcase
	endfunction

	function automatic logic is_dm(input prs_psc_t m);
		is_dm = !(m == PRS_FD1 || m == PRS_FD2 || m == PRS_FD3);
	endfunction

	// Register writes; counter reset bits stay until software clears them
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pll_ctrl <= PLL_CTRL_RST;
			r_lo <= ZERO_RST;
			r_hi <= ZERO_RST;
			a_reg <= ZERO_RST;
			b_lo <= ZERO_RST;
			b_hi <= ZERO_RST;
			psc_reg <= ZERO_RST;
			ld_ctrl <= ZERO_RST;
			sync_ctrl <= ZERO_RST;
			mon_cfg <= ZERO_RST;
			ref_ctrl <= ZERO_RST;
			ref_pref <= ZERO_RST;
		end else if (ce_in && wr_en_in) begin
			if (addr_in == REG_PLL_CTRL) begin
				pll_ctrl <= wr_data_in;
			end else if (addr_in == REG_RDIV_LO) begin
				r_lo <= wr_data_in;
			end else if (addr_in == REG_RDIV_HI) begin
				r_hi <= wr_data_in;
			end else if (addr_in == REG_ADIV) begin
				a_reg <= wr_data_in;
			end else if (addr_in == REG_BDIV_LO) begin
				b_lo <= wr_data_in;
			end else if (addr_in == REG_BDIV_HI) begin
				b_hi <= wr_data_in;
			end else if (addr_in == REG_PSC) begin
				psc_reg <= wr_data_in;
			end else if (addr_in == REG_LD_CTRL) begin
				ld_ctrl <= wr_data_in;
			end else if (addr_in == REG_SYNC_CTRL) begin
				sync_ctrl <= wr_data_in;
			end else if (addr_in == REG_MON_CFG) begin
				mon_cfg <= wr_data_in;
			end else if (addr_in == REG_REF_CTRL) begin
				ref_ctrl <= wr_data_in;
			end else if (addr_in == REG_REF_PREF) begin
				ref_pref <= wr_data_in;
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= ZERO_RST;
		end else if (ce_in) begin
			rd_data_out <= ZERO_RST;
			if (rd_en_in) begin
				if (addr_in == REG_PLL_CTRL) begin
					rd_data_out <= pll_ctrl;
				end else if (addr_in == REG_RDIV_LO) begin
					rd_data_out <= r_lo;
				end else if (addr_in == REG_RDIV_HI) begin
					rd_data_out <= {2'h0, r_hi[5:0]};
				end else if (addr_in == REG_ADIV) begin
					rd_data_out <= {2'h0, a_reg[5:0]};
				end else if (addr_in == REG_BDIV_LO) begin
					rd_data_out <= b_lo;
				end else if (addr_in == REG_BDIV_HI) begin
					rd_data_out <= {3'h0, b_hi[4:0]};
				end else if (addr_in == REG_PSC) begin
					rd_data_out <= psc_reg;
				end else if (addr_in == REG_LD_CTRL) begin
					rd_data_out <= ld_ctrl;
				end else if (addr_in == REG_SYNC_CTRL) begin
					rd_data_out <= sync_ctrl;
				end else if (addr_in == REG_MON_CFG) begin
					rd_data_out <= mon_cfg;
				end else if (addr_in == REG_REF_CTRL) begin
					rd_data_out <= ref_ctrl;
				end else if (addr_in == REG_REF_PREF) begin
					rd_data_out <= ref_pref;
				end else if (addr_in == REG_STATUS) begin
					rd_data_out <= {3'h0, sync_rst, pending, sel_sec, ref_valid};
				end
			end
		end
	end

	// Pin synchronisers; a level counts once stages two and three agree
	assign pin_raw = {ref_select_pin_in, sync_n_in, vco_feedback_in,
		secondary_reference_input_in, primary_reference_input_in};
	for (genvar i = 0; i < NPIN; i++) begin : g_pin
		always_ff @(posedge core_clk_in or posedge rst_in) begin
			if (rst_in) begin
				s1[i] <= PIN_IDLE[i];
				s2[i] <= PIN_IDLE[i];
				s3[i] <= PIN_IDLE[i];
				filt[i] <= PIN_IDLE[i];
			end else if (ce_in) begin
				s1[i] <= pin_raw[i];
				s2[i] <= s1[i];
				s3[i] <= s2[i];
				if (s2[i] == s3[i]) begin
					filt[i] <= s3[i];
				end
			end
		end
		assign rise[i] = (s2[i] == s3[i]) && s3[i] && !filt[i];
		assign fall[i] = (s2[i] == s3[i]) && !s3[i] && filt[i];
	end

	// Reference activity monitors; invalid after a gap with no edge
	for (genvar k = 0; k < 2; k++) begin : g_mon
		always_ff @(posedge core_clk_in or posedge rst_in) begin
			if (rst_in) begin
				loss_cnt[k] <= LOSS_LIM;
			end else if (ce_in) begin
				if (rise[k]) begin
					loss_cnt[k] <= '0;
				end else if (loss_cnt[k] != LOSS_LIM) begin
					loss_cnt[k] <= loss_cnt[k] + LW'(1);
				end
			end
		end
		assign ref_valid[k] = (loss_cnt[k] != LOSS_LIM);
	end

	// Power and mode decode
	assign pll_pd = (pll_ctrl[1:0] != PLL_PD_NORMAL);
	assign diff_sel = ref_ctrl[REF_DIFF_BIT];
	assign pri_en = ref_ctrl[REF_PRI_EN_BIT];
	assign sec_en = ref_ctrl[REF_SEC_EN_BIT];
	assign deg_dis = ref_ctrl[REF_DEGLITCH_DIS_BIT];
	assign dual = pri_en && sec_en && !diff_sel;
	assign diff_rx_pd_out = !diff_sel || pll_pd;
	assign primary_buf_pd_out = pll_pd || !pri_en || diff_sel;
	assign secondary_buf_pd_out = pll_pd || !sec_en || diff_sel;
	assign se_offset_out = ld_ctrl[LD_SE_OFFSET_BIT];
	assign crystal_oscillator_enable_out = ref_ctrl[REF_XTAL_BIT] && !pll_pd;

	// Monitor and status pins, registered
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			reference_monitor_output_out <= 1'b0;
			status_out <= 1'b0;
		end else if (ce_in) begin
			reference_monitor_output_out <= (mon_cfg[3:0] == MON_PRI_LOST && !ref_valid[0])
				|| (mon_cfg[3:0] == MON_SEC_LOST && !ref_valid[1]);
			status_out <= (mon_cfg[7:4] == STAT_PRI_LOST && !ref_valid[0])
				|| (mon_cfg[7:4] == STAT_SEC_LOST && !ref_valid[1]);
		end
	end

	// Selection target; automatic mode always returns to the preferred input
	assign drive = ref_pref[PREF_STATUS_BIT] ? status_out : reference_monitor_output_out;
	assign fixed_sec = sec_en && !pri_en && !diff_sel;
	always_comb begin
		if (!dual) begin
			target_sec = fixed_sec;
		end else if (ref_ctrl[REF_AUTO_BIT]) begin
			target_sec = ref_pref[PREF_SEC_BIT] ^ drive;
		end else if (ref_ctrl[REF_PIN_SEL_BIT]) begin
			target_sec = filt[4];
		end else begin
			target_sec = ref_ctrl[REF_MAN_SEC_BIT];
		end
	end

	// Switchover waits for an edge of the new input when deglitching;
	// a dead target leaves the mux stuck, so software must check it first
	assign new_edge = target_sec ? rise[1] : rise[0];
	assign pending = (target_sec != sel_sec);
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sel_sec <= 1'b0;
		end else if (ce_in && pending && (deg_dis || new_edge)) begin
			sel_sec <= target_sec;
		end
	end
	assign ref_sel_secondary_out = sel_sec;

	// Edge into the reference divider; blocked while a switch is pending
	assign path_on = !pll_pd && (diff_sel || ref_ctrl[REF_XTAL_BIT]
		|| (sel_sec ? sec_en : pri_en));
	assign ref_edge = path_on && !pending && (sel_sec ? rise[1] : rise[0]);

	// Counter resets from bits and sync pin
	assign sync_mode = prs_sync_t'(sync_ctrl[SYNC_LSB+1:SYNC_LSB]);
	assign sync_rst = (sync_mode == PRS_SYNC_LEVEL && !filt[3])
		|| (sync_mode == PRS_SYNC_EDGE && fall[3]);
	assign r_rst = psc_reg[PSC_R_RST_BIT] || psc_reg[PSC_SHARED_RST_BIT] || sync_rst;
	assign n_rst = psc_reg[PSC_AB_RST_BIT] || psc_reg[PSC_SHARED_RST_BIT] || sync_rst;

	// Reference divider; new value loads at terminal count or on counter reset
	assign r_val = {r_hi[5:0], r_lo};
	assign r_eff = (r_load <= R_ONE) ? R_ONE : r_load;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			r_cnt <= '0;
			r_load <= '0;
			r_div_pulse_out <= 1'b0;
		end else if (ce_in) begin
			r_div_pulse_out <= 1'b0;
			if (r_rst) begin
				r_cnt <= '0;
				r_load <= r_val;
			end else if (ref_edge) begin
				if (r_cnt == r_eff - R_ONE) begin
					r_cnt <= '0;
					r_load <= r_val;
					r_div_pulse_out <= 1'b1;
				end else begin
					r_cnt <= r_cnt + R_ONE;
				end
			end
		end
	end

	// Feedback divider: prescaler of P or P+1, swallow and main counters.
	// The first A prescaler cycles use P+1, the rest P, giving P*B+A.
	assign psc_mode = prs_psc_t'(psc_reg[2:0]);
	assign a_val = a_reg[5:0];
	assign b_val = {b_hi[4:0], b_lo};
	assign b_eff = (b_val <= B_ONE) ? B_ONE : b_val;
	assign a_eff = (is_dm(psc_mode) && b_val > B_ONE) ? a_val : '0;
	assign p_mod = p_base(psc_q) + ((is_dm(psc_q) && a_cnt != '0) ? P_ONE : '0);
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			psc_cnt <= '0;
			a_cnt <= '0;
			b_cnt <= B_ONE;
			psc_q <= PRS_FD1;
			n_div_pulse_out <= 1'b0;
		end else if (ce_in) begin
			n_div_pulse_out <= 1'b0;
			if (n_rst) begin
				psc_cnt <= '0;
				a_cnt <= a_eff;
				b_cnt <= b_eff;
				psc_q <= psc_mode;
			end else if (rise[2] && !pll_pd) begin
				if (psc_cnt == p_mod - P_ONE) begin
					psc_cnt <= '0;
					if (b_cnt <= B_ONE) begin
						a_cnt <= a_eff;
						b_cnt <= b_eff;
						psc_q <= psc_mode;
						n_div_pulse_out <= 1'b1;
					end else begin
						b_cnt <= b_cnt - B_ONE;
						a_cnt <= (a_cnt != '0) ? a_cnt - A_ONE : a_cnt;
					end
				end else begin
					psc_cnt <= psc_cnt + P_ONE;
				end
			end
		end
	end

	// Checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_div1_edge;
		ce_in && !r_rst && ref_edge && r_load <= R_ONE;
	endsequence
	sequence s_switch_wait;
		ce_in && pending && !deg_dis && !new_edge;
	endsequence

	a_inputs_off: assert property (
		(!pri_en && !sec_en && !diff_sel && !ref_ctrl[REF_XTAL_BIT])
			|-> (primary_buf_pd_out && secondary_buf_pd_out
			&& diff_rx_pd_out && !ref_edge)) else $error("reference path on while disabled");
	a_diff_rx_pd: assert property (
		(!diff_sel || pll_ctrl[1:0] != PLL_PD_NORMAL) |-> diff_rx_pd_out)
		else $error("differential receiver powered wrongly");
	a_se_buf_pd: assert property (
		(diff_sel || pll_pd) |-> (primary_buf_pd_out && secondary_buf_pd_out))
		else $error("single-ended buffer powered wrongly");
	a_offset_bias: assert property (
		se_offset_out == ld_ctrl[LD_SE_OFFSET_BIT]) else $error("offset bias mismatch");
	a_xtal_gate: assert property (
		crystal_oscillator_enable_out |-> ref_ctrl[REF_XTAL_BIT])
		else $error("crystal amplifier on without enable");
	a_no_switch: assert property (
		(ce_in && !dual && !sel_sec && !fixed_sec) |=> !sel_sec)
		else $error("switch outside dual mode");
	a_monitor_lost: assert property (
		(ce_in && mon_cfg[3:0] == MON_PRI_LOST && !ref_valid[0]) |=> reference_monitor_output_out)
		else $error("monitor not high on primary loss");
	a_deglitch_hold: assert property (
		s_switch_wait |=> ($stable(sel_sec) && !r_div_pulse_out))
		else $error("edge or switch during deglitch wait");
	a_revert_pref: assert property (
		(ce_in && dual && ref_ctrl[REF_AUTO_BIT] && deg_dis && !ref_pref[PREF_SEC_BIT]
			&& !drive) |=> !sel_sec) else $error("no revert to preferred input");
	a_div_by_one: assert property (
		s_div1_edge |=> r_div_pulse_out) else $error("R divider not dividing by one");
	a_r_reset: assert property (
		(ce_in && r_rst) |=> (r_cnt == '0 && !r_div_pulse_out))
		else $error("R divider not held in reset");
	a_ab_reset: assert property (
		(ce_in && psc_reg[PSC_AB_RST_BIT]) |=> (psc_cnt == '0 && !n_div_pulse_out))
		else $error("feedback counters not held in reset");

endmodule

// [prs_clk_src.sv]
/*
 * Behavioural clock source standing in for a reference oscillator or
 * the VCO feedback. Assumes the bench starts and stops it with run_in.
 */
`timescale 1ns/1ps

module prs_clk_src #(
	parameter int HALF = 5
) (
	// Timing base
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Control
	input wire logic run_in,
	// Clock towards the block
	output logic clk_out
);
	int cnt;

	// Toggle every HALF cycles; a stop always finishes the high phase, so no runt pulse
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= 0;
			clk_out <= 1'h0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			clk_out <= (run_in || clk_out) ? ~clk_out : 1'h0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// [tb_top.sv]
/*
 * Self-checking bench for the reference select and divider block.
 * Assumes three behavioural clock sources and a shortened loss timeout.
 */
`timescale 1ns/1ps

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
	$display("unexpected at %0t: got %0h exp %0h", $time, (got), (exp)); end end

module tb_top import prs_pkg::*;;
	localparam int LOSS = 16;
	logic core_clk_in = 1'h0;
	logic rst_in = 1'h1;
	logic ce_in = 1'h1;
	logic [ADDR_W-1:0] addr_in = 9'h000;
	logic [DATA_W-1:0] wr_data_in = 8'h00;
	logic wr_en_in = 1'h0;
	logic rd_en_in = 1'h0;
	logic sync_n_in = 1'h1;
	logic ref_select_pin_in = 1'h0;
	logic run_pri = 1'h0;
	logic run_sec = 1'h0;
	logic run_vco = 1'h0;
	logic pri_clk, sec_clk, vco_clk, diff_pd, pri_pd, sec_pd, offset, xtal;
	logic sel_sec, mon, stat, r_pulse, n_pulse;
	logic [DATA_W-1:0] rd_data_out;
	logic [DATA_W-1:0] exp_rd;
	logic [DATA_W-1:0] rd_q[$];
	int r_q[$];
	int n_q[$];
	int exp_e, bad_count = 0, checks = 0, pri_edges = 0, vco_edges = 0;
	logic rd_seen = 1'h0;
	logic watch = 1'h0;
	logic [7:0] cur_psc = 8'h00;
	logic [31:0] seed = 32'h0000E1FC;

	prs_ref_ctrl #(.LOSS_CYC(LOSS)) prs_ref_ctrl_inst (.core_clk_in(core_clk_in),
		.rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
		.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
		.primary_reference_input_in(pri_clk), .secondary_reference_input_in(sec_clk),
		.vco_feedback_in(vco_clk), .sync_n_in(sync_n_in),
		.ref_select_pin_in(ref_select_pin_in), .diff_rx_pd_out(diff_pd),
		.primary_buf_pd_out(pri_pd), .secondary_buf_pd_out(sec_pd), .se_offset_out(offset),
		.crystal_oscillator_enable_out(xtal), .ref_sel_secondary_out(sel_sec),
		.reference_monitor_output_out(mon), .status_out(stat),
		.r_div_pulse_out(r_pulse), .n_div_pulse_out(n_pulse));
	prs_clk_src pri_src (.core_clk_in(core_clk_in), .rst_in(rst_in), .run_in(run_pri),
		.clk_out(pri_clk));
	prs_clk_src sec_src (.core_clk_in(core_clk_in), .rst_in(rst_in), .run_in(run_sec),
		.clk_out(sec_clk));
	prs_clk_src vco_src (.core_clk_in(core_clk_in), .rst_in(rst_in), .run_in(run_vco),
		.clk_out(vco_clk));

	// Free-running core clock
	always #20 core_clk_in = ~core_clk_in;
	// Edge counts used as the measure of divide ratios
	always @(posedge pri_clk) pri_edges++;
	always @(posedge vco_clk) vco_edges++;

	// Results are matched against the oldest note; a pulse with no note is a mismatch
	always @(posedge core_clk_in) begin
		if (rd_seen) begin
			exp_rd = rd_q.pop_front();
			`CHK(rd_data_out, exp_rd)
		end
		rd_seen = rd_en_in;
		if (watch && r_pulse === 1'h1) begin
			exp_e = (r_q.size() > 0) ? r_q.pop_front() : -1;
			`CHK(pri_edges, exp_e)
		end
		if (watch && n_pulse === 1'h1) begin
			exp_e = (n_q.size() > 0) ? n_q.pop_front() : -1;
			`CHK(vco_edges, exp_e)
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic sig(input int i);
		case (i)
			0: return sel_sec;
			1: return mon;
			default: return stat;
		endcase
	endfunction

	task automatic finish_test();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk_in);
		wr_en_in <= 1'h1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge core_clk_in);
		wr_en_in <= 1'h0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		rd_q.push_back(e);
		@(posedge core_clk_in);
		rd_en_in <= 1'h1;
		addr_in <= a;
		@(posedge core_clk_in);
		rd_en_in <= 1'h0;
	endtask

	task automatic chk_pd(input logic [3:0] e);
		@(negedge core_clk_in);
		`CHK({diff_pd, pri_pd, sec_pd, xtal}, e)
	endtask

	// A timeout here counts as a mismatch and ends the run
	task automatic wait_sig(input int i, input logic v, input int lim);
		for (int k = 0; k < lim && sig(i) !== v; k++) begin
			@(negedge core_clk_in);
		end
		`CHK(sig(i), v)
		if (sig(i) !== v) begin
			finish_test();
		end
	endtask

	// Restart counters, send an exact edge burst, expect a pulse every ratio edges
	task automatic run_div(input int sel, input int ratio, input int edges, input logic [7:0] rb);
		int k;
		wr(REG_PSC, cur_psc | 8'h20);
		wr(REG_PSC, cur_psc | rb);
		pri_edges = 0;
		vco_edges = 0;
		for (k = 1; ratio > 0 && k * ratio <= edges; k++) begin
			if (sel == 0) begin
				r_q.push_back(k * ratio);
			end else begin
				n_q.push_back(k * ratio);
			end
		end
		watch = 1'h1;
		run_pri <= (sel == 0);
		run_vco <= (sel != 0);
		for (k = 0; k < edges * 40 && pri_edges + vco_edges < edges; k++) begin
			@(posedge core_clk_in);
		end
		run_pri <= 1'h0;
		run_vco <= 1'h0;
		repeat (30) @(posedge core_clk_in);
		watch = 1'h0;
		`CHK(pri_edges + vco_edges + r_q.size() + n_q.size(), edges)
		if (pri_edges + vco_edges < edges) begin
			finish_test();
		end
	endtask

	// Register addresses, power table {ctrl, pll, exp}, feedback table {P, B, A, N}
	logic [8:0] ra[14] = '{REG_PLL_CTRL, REG_RDIV_LO, REG_RDIV_HI, REG_ADIV, REG_BDIV_LO,
		REG_BDIV_HI, REG_PSC, REG_LD_CTRL, REG_SYNC_CTRL, REG_MON_CFG, REG_REF_CTRL,
		REG_REF_PREF, REG_STATUS, 9'h017};
	logic [15:0] pw[7] = '{16'h000E, 16'h0106, 16'h0608, 16'h0706, 16'h040C, 16'h0907,
		16'h0F1E};
	logic [31:0] nt[10] = '{32'h00100001, 32'h10302006, 32'h70301009, 32'h20301007,
		32'h3030200E, 32'h40300018, 32'h50301031, 32'h60303063, 32'h20100002,
		32'h30100004};

	// Main sequence
	initial begin
		logic [13:0] rv[4];
		int rr;
		repeat (4) @(posedge core_clk_in);
		rst_in <= 1'h0;
		chk_pd(4'hE);
		`CHK(offset, 1'h0)
		foreach (ra[i]) begin
			rd(ra[i], (ra[i] == REG_PLL_CTRL) ? PLL_CTRL_RST : ZERO_RST);
		end
		wr(9'h01A, 8'hFF);
		rd(9'h01A, 8'h00);
		foreach (pw[i]) begin
			wr(REG_PLL_CTRL, {6'h00, pw[i][5:4]});
			wr(REG_REF_CTRL, pw[i][15:8]);
			chk_pd(pw[i][3:0]);
		end
		wr(REG_LD_CTRL, 8'h80);
		@(negedge core_clk_in);
		`CHK(offset, 1'h1)
		// A write while the clock enable is low must be lost
		@(posedge core_clk_in);
		ce_in <= 1'h0;
		wr(REG_LD_CTRL, 8'h00);
		ce_in <= 1'h1;
		`CHK(offset, 1'h1)
		wr(REG_PLL_CTRL, 8'h00);
		wr(REG_REF_CTRL, 8'h02);
		sync_n_in <= 1'h0;
		seed = xs(seed);
		rv = '{14'h0000, 14'h0001, {10'h000, seed[3:0]} + 14'h0002, 14'h0101};
		foreach (rv[i]) begin
			rr = (rv[i] < 14'h0002) ? 1 : int'(rv[i]);
			wr(REG_RDIV_LO, rv[i][7:0]);
			wr(REG_RDIV_HI, {2'h0, rv[i][13:8]});
			rd(REG_RDIV_LO, rv[i][7:0]);
			run_div(0, rr, 2 * rr + 1, 8'h00);
		end
		// Back to divide by one; later runs expect a pulse per edge, or none while a counter reset holds the divider
		wr(REG_RDIV_LO, 8'h01);
		wr(REG_RDIV_HI, 8'h00);
		wr(REG_SYNC_CTRL, 8'h40);
		run_div(0, 0, 4, 8'h00);
		// Edge mode does not hold the counters while the pin stays low
		wr(REG_SYNC_CTRL, 8'h80);
		run_div(0, 1, 3, 8'h00);
		sync_n_in <= 1'h1;
		wr(REG_SYNC_CTRL, 8'h00);
		run_div(0, 0, 4, 8'h40);
		run_div(0, 1, 3, 8'h10);
		run_div(0, 0, 4, 8'h20);
		rd(REG_PSC, 8'h20);
		foreach (nt[i]) begin
			cur_psc = {5'h00, nt[i][30:28]};
			wr(REG_ADIV, nt[i][19:12]);
			wr(REG_BDIV_LO, nt[i][27:20]);
			wr(REG_BDIV_HI, 8'h00);
			run_div(1, int'(nt[i][11:0]), 2 * int'(nt[i][11:0]) + 1, 8'h00);
		end
		run_div(1, 0, 4, 8'h10);
		rd(REG_PSC, cur_psc | 8'h10);
		wr(REG_MON_CFG, 8'hF7);
		wr(REG_REF_CTRL, 8'h26);
		run_pri <= 1'h1;
		run_sec <= 1'h1;
		wait_sig(1, 1'h0, 80);
		wait_sig(0, 1'h0, 80);
		run_pri <= 1'h0;
		wait_sig(1, 1'h1, 80);
		wait_sig(0, 1'h1, 80);
		rd(REG_STATUS, 8'h06);
		run_pri <= 1'h1;
		wait_sig(1, 1'h0, 80);
		wait_sig(0, 1'h0, 80);
		wr(REG_REF_PREF, 8'h03);
		wait_sig(0, 1'h1, 80);
		run_pri <= 1'h0;
		wait_sig(2, 1'h1, 80);
		run_pri <= 1'h1;
		wr(REG_REF_PREF, 8'h00);
		wait_sig(0, 1'h0, 80);
		wr(REG_REF_CTRL, 8'h16);
		wait_sig(0, 1'h1, 80);
		wr(REG_REF_CTRL, 8'h46);
		wait_sig(0, 1'h0, 80);
		ref_select_pin_in <= 1'h1;
		wait_sig(0, 1'h1, 80);
		ref_select_pin_in <= 1'h0;
		wr(REG_REF_CTRL, 8'h12);
		repeat (40) @(posedge core_clk_in);
		wait_sig(0, 1'h0, 1);
		wr(REG_REF_CTRL, 8'h06);
		run_sec <= 1'h0;
		repeat (10) @(posedge core_clk_in);
		wr(REG_REF_CTRL, 8'h16);
		repeat (40) @(posedge core_clk_in);
		wait_sig(0, 1'h0, 1);
		run_sec <= 1'h1;
		wait_sig(0, 1'h1, 40);
		run_pri <= 1'h0;
		repeat (40) @(posedge core_clk_in);
		wr(REG_REF_CTRL, 8'h86);
		wait_sig(0, 1'h0, 3);
		finish_test();
	end
endmodule
